/* src/apf_defs.vh */
/*
 Constants for the amplifier protection and fault-reporting block.
 Assumes inclusion by apf_protect.v only.
*/
`ifndef APF_DEFS_VH
`define APF_DEFS_VH
// Output configuration codes
`define APF_MODE_BRIDGE   2'h0
`define APF_MODE_PARALLEL 2'h1
`define APF_MODE_SINGLE   2'h2
// Strap codes: 8..b select latched mode, 0..3 cycle-by-cycle, bits 1:0 select threshold
`define APF_STRAP_W       4
`define APF_STRAP_CBC_LO  4'h0
`define APF_STRAP_CBC_HI  4'h3
`define APF_STRAP_LAT_LO  4'h8
`define APF_STRAP_LAT_HI  4'hb
// Threshold codes: 0 = 16.3 A, 1 = 15.1 A, 2 = 13.5 A, 3 = 12.3 A (minimum)
`define APF_THR_MIN       2'h3
// Overload counter
`define APF_OLC_W         4
`define APF_OLC_MAX       4'hf
// Half-bridge bit positions
`define APF_HB_A          0
`define APF_HB_B          1
`define APF_HB_C          2
`define APF_HB_D          3
`endif

/* src/apf_protect.v */
/*
 Protection and fault reporting for four half-bridges A..D: config
 shutdown mapping, cycle-by-cycle current limit with overload counter,
 latched overcurrent, thermal shutdown and the two status outputs.
 Assumes all detection flags are synchronous to CORE_CLK, the PWM frame
 clock domain, and that FRAME_START pulses once per PWM frame.
*/
// Summary of operation
// RULE1: Both status outputs active-low open-drain style
// RULE2: Any shutdown fault pulls fault output low
// RULE3: Temperature warning pulls warning output low
// RULE4: Output pair encodes normal, warning, fault, both
// RULE5: Reset low forces fault output high
// RULE6: Fault immediately sets stages Hi-Z, fault low
// RULE7: Non-overload, non-thermal faults recover automatically
// RULE8: Local error mapped per output configuration
// RULE9: Bootstrap undervoltage only disables own half-bridge
// RULE10: One threshold for all switches, two modes
// RULE11: Overcurrent flips half-bridge until next frame
// RULE12: Counter up on overcurrent, down otherwise; max shuts
// RULE13: Overload shutdown holds until reset cycle
// RULE14: Latched mode shuts on first overcurrent
// RULE15: Strap selects mode and threshold
// RULE16: Invalid strap gives minimum threshold
// RULE17: Controller releases reset after supplies settle
// RULE18: Controller watches warning, lowers volume
// RULE19: Overtemperature latches all Hi-Z until reset
// RULE20: Controller toggles reset to clear latched fault
// RULE21: Detections arrive as synchronous flags
`timescale 1ns/1ps
`include "apf_defs.vh"
module apf_protect (
	input  wire       CORE_CLK,
	input  wire       RST_N,
	input  wire       CLK_EN,
	input  wire       FRAME_START,
	input  wire [1:0] OUTPUT_MODE,
	input  wire [3:0] CURRENT_LIMIT_STRAP,
	input  wire       TEMP_WARNING,
	input  wire       THERMAL_LIMIT,
	input  wire       UNDERVOLTAGE_PROTECTION,
	input  wire [3:0] BOOTSTRAP_UV,
	input  wire [3:0] OVERCURRENT,
	output wire       FAULT_N_O,
	output wire       FAULT_N_OE,
	output wire       CLIP_TEMP_WARN_N_O,
	output wire       CLIP_TEMP_WARN_N_OE,
	output reg  [3:0] HB_HIZ,
	output reg  [3:0] HB_FLIP,
	output reg  [1:0] OC_THRESHOLD,
	output reg        CYCLE_CURRENT_LIMIT,
	output reg        OVERLOAD_PROTECTION,
	output reg        THERMAL_SHUTDOWN
);

	// Bridge-tied: a B error takes A and D, as tabulated
	function [3:0] map_bridge;
		input [3:0] err;
		begin
			map_bridge = 4'h0;
			if (err[`APF_HB_A])
				map_bridge = map_bridge | 4'h3;
			if (err[`APF_HB_B])
				map_bridge = map_bridge | 4'h9;
			if (err[`APF_HB_C] | err[`APF_HB_D])
				map_bridge = map_bridge | 4'hc;
		end
	endfunction

	// Single-ended: errors stay within their own pair
	function [3:0] map_single;
		input [3:0] err;
		begin
			map_single = 4'h0;
			if (err[`APF_HB_A] | err[`APF_HB_B])
				map_single = map_single | 4'h3;
			if (err[`APF_HB_C] | err[`APF_HB_D])
				map_single = map_single | 4'hc;
		end
	endfunction

	// Maps per-half-bridge local errors to the set switched off
	function [3:0] map_off;
		input [1:0] mode;
		input [3:0] err;
		begin
			case (mode)
			`APF_MODE_PARALLEL:
				map_off = (|err) ? 4'hf : 4'h0;
			`APF_MODE_SINGLE:
				map_off = map_single(err);
			default:
				map_off = map_bridge(err);
			endcase
		end
	endfunction

	// Counter step: up per event, down once per quiet frame, saturating
	function [`APF_OLC_W-1:0] olc_step;
		input [`APF_OLC_W-1:0] cnt;
		input                  oc;
		input                  frame;
		input                  seen;
		begin
			olc_step = cnt;
			if (oc) begin
				if (cnt != `APF_OLC_MAX)
					olc_step = cnt + 1'b1;
			end else if (frame && !seen) begin
				if (cnt != {`APF_OLC_W{1'b0}})
					olc_step = cnt - 1'b1;
			end
		end
	endfunction

	// Trips on the event that takes the counter to its top, or at the top
	function olc_trip;
		input [`APF_OLC_W-1:0] cnt;
		input                  oc;
		begin
			olc_trip = (oc && (cnt == `APF_OLC_MAX - 1'b1)) || (cnt == `APF_OLC_MAX);
		end
	endfunction

	// Strap decoding; codes outside both ranges fall back to the minimum
	function strap_cbc;
		input [`APF_STRAP_W-1:0] code;
		begin
			strap_cbc = (code <= `APF_STRAP_CBC_HI);
		end
	endfunction

	function strap_lat;
		input [`APF_STRAP_W-1:0] code;
		begin
			strap_lat = (code >= `APF_STRAP_LAT_LO) && (code <= `APF_STRAP_LAT_HI);
		end
	endfunction

	function [1:0] strap_thr;
		input [`APF_STRAP_W-1:0] code;
		begin
			if (strap_cbc(code) || strap_lat(code))
				strap_thr = code[1:0];
			else
				strap_thr = `APF_THR_MIN;
		end
	endfunction

	reg  [`APF_OLC_W-1:0] olc_q [0:3];
	reg  [`APF_OLC_W-1:0] olc_d [0:3];
	reg  [3:0]            ol_latch_q;
	reg  [3:0]            latch_d;
	reg  [3:0]            oc_seen_q;
	reg  [3:0]            seen_d;
	reg  [3:0]            flip_d;
	reg                   therm_q;
	reg                   therm_d;
	reg                   strap_taken_q;
	reg                   taken_d;
	reg                   latched_mode_q;
	reg                   latched_mode_d;
	reg  [1:0]            thr_q;
	reg  [1:0]            thr_d;
	reg  [3:0]            hiz_d;
	reg                   fault_d;
	integer               i;
	integer               j;

	// Strap caught once after reset release, never under the reset itself
	always @* begin
		taken_d        = strap_taken_q;
		latched_mode_d = latched_mode_q;
		thr_d          = thr_q;
		if (!strap_taken_q) begin
			taken_d        = 1'b1;
			latched_mode_d = strap_lat(CURRENT_LIMIT_STRAP); //RULE15
			thr_d          = strap_thr(CURRENT_LIMIT_STRAP); //RULE16
		end
	end

	// Later strap changes are ignored until the next reset
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			strap_taken_q  <= 1'b0;
			latched_mode_q <= 1'b0;
			thr_q          <= `APF_THR_MIN;
		end else if (CLK_EN) begin
			strap_taken_q  <= taken_d;
			latched_mode_q <= latched_mode_d;
			thr_q          <= thr_d;
		end
	end

	// Next state per half-bridge; a new event at frame start keeps the flip
	always @* begin
		therm_d = therm_q | THERMAL_LIMIT; //RULE19 RULE21
		for (i = 0; i < 4; i = i + 1) begin
			olc_d[i]   = olc_q[i];
			latch_d[i] = ol_latch_q[i];
			flip_d[i]  = HB_FLIP[i];
			if (latched_mode_q) begin
				if (OVERCURRENT[i])
					latch_d[i] = 1'b1; //RULE14
			end else begin //RULE10
				if (OVERCURRENT[i])
					flip_d[i] = 1'b1; //RULE11
				else if (FRAME_START)
					flip_d[i] = 1'b0; //RULE11
				olc_d[i] = olc_step(olc_q[i], OVERCURRENT[i],
					FRAME_START, oc_seen_q[i]); //RULE12
				if (olc_trip(olc_q[i], OVERCURRENT[i]))
					latch_d[i] = 1'b1; //RULE13
			end
			// Tracks overcurrent within the current frame
			if (FRAME_START)
				seen_d[i] = OVERCURRENT[i];
			else
				seen_d[i] = oc_seen_q[i] | OVERCURRENT[i];
		end
	end

	// Latches clear only through reset, never through a quiet frame
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (j = 0; j < 4; j = j + 1)
				olc_q[j] <= {`APF_OLC_W{1'b0}};
			ol_latch_q <= 4'h0;
			oc_seen_q  <= 4'h0;
			HB_FLIP    <= 4'h0;
			therm_q    <= 1'b0;
		end else if (CLK_EN) begin
			for (j = 0; j < 4; j = j + 1)
				olc_q[j] <= olc_d[j];
			ol_latch_q <= latch_d;
			oc_seen_q  <= seen_d;
			HB_FLIP    <= flip_d;
			therm_q    <= therm_d;
		end
	end

	// Combinational shutdown; HB_HIZ registers it, so Hi-Z follows the detection one edge later
	always @* begin
		hiz_d   = map_off(OUTPUT_MODE, ol_latch_q | (latched_mode_q ? OVERCURRENT : 4'h0)); //RULE8
		fault_d = (|ol_latch_q) | (latched_mode_q & (|OVERCURRENT)); //RULE2
		if (UNDERVOLTAGE_PROTECTION || therm_q || THERMAL_LIMIT) begin //RULE7
			hiz_d   = 4'hf; //RULE6
			fault_d = 1'b1; //RULE6
		end
		hiz_d = hiz_d | BOOTSTRAP_UV; //RULE9
	end

	reg                   ccl_d;
	reg                   ovl_d;
	reg                   tshut_d;

	// Mode flag only shows once the strap has been taken
	always @* begin
		ccl_d   = strap_taken_q & ~latched_mode_q;
		ovl_d   = |ol_latch_q;
		tshut_d = therm_q | THERMAL_LIMIT;
	end

	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HB_HIZ              <= 4'hf;
			OC_THRESHOLD        <= `APF_THR_MIN;
			CYCLE_CURRENT_LIMIT <= 1'b0;
			OVERLOAD_PROTECTION <= 1'b0;
			THERMAL_SHUTDOWN    <= 1'b0;
		end else if (CLK_EN) begin
			HB_HIZ              <= hiz_d;
			OC_THRESHOLD        <= thr_q; //RULE10
			CYCLE_CURRENT_LIMIT <= ccl_d;
			OVERLOAD_PROTECTION <= ovl_d;
			THERMAL_SHUTDOWN    <= tshut_d;
		end
	end

	// Status pins: drive low only, pull-up outside gives the high level
	reg fault_pin_q;
	reg warn_pin_q;
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			fault_pin_q <= 1'b0; //RULE5
		else if (CLK_EN)
			fault_pin_q <= fault_d; //RULE4
	end

	// Warning is self-clearing and follows the flag one edge late
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			warn_pin_q <= 1'b0;
		else if (CLK_EN)
			warn_pin_q <= TEMP_WARNING; //RULE3
	end

	assign FAULT_N_O           = 1'b0; //RULE1
	assign FAULT_N_OE          = fault_pin_q & RST_N; //RULE5
	assign CLIP_TEMP_WARN_N_O  = 1'b0; //RULE1
	assign CLIP_TEMP_WARN_N_OE = warn_pin_q; //RULE4

endmodule

/* tb/apf_chk_sva.sv */
/* Port checker for apf_protect.
 Timed checks other than a_ovl_hold and a_hot_latch wait for CLK_EN, which the bench drops for two cycles. */
`timescale 1ns/1ps
module apf_chk (
	input logic       CORE_CLK,
	input logic       RST_N,
	input logic       CLK_EN,
	input logic       FRAME_START,
	input logic       TEMP_WARNING,
	input logic       UNDERVOLTAGE_PROTECTION,
	input logic [3:0] BOOTSTRAP_UV,
	input logic [3:0] OVERCURRENT,
	input logic       FAULT_N_O,
	input logic       FAULT_N_OE,
	input logic       CLIP_TEMP_WARN_N_O,
	input logic       CLIP_TEMP_WARN_N_OE,
	input logic [3:0] HB_HIZ,
	input logic [3:0] HB_FLIP,
	input logic       CYCLE_CURRENT_LIMIT,
	input logic       OVERLOAD_PROTECTION,
	input logic       THERMAL_SHUTDOWN
);
	logic [1:0] up_q;
	wire        ok = (up_q == 2'h3) && CLK_EN;
	// Strap sample edge settles first
	always @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N) up_q <= 2'h0;
		else if (up_q != 2'h3) up_q <= up_q + 2'h1;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	a_od_low: assert property (!FAULT_N_O && !CLIP_TEMP_WARN_N_O)
		else $error("status data high");
	a_uv_off: assert property (ok && UNDERVOLTAGE_PROTECTION |=> FAULT_N_OE && HB_HIZ == 4'hf)
		else $error("uv not shut");
	a_warn_follow: assert property (ok |=> CLIP_TEMP_WARN_N_OE == $past(TEMP_WARNING))
		else $error("warn wrong");
	a_rst_fault: assert property (disable iff (1'b0) !RST_N |-> !FAULT_N_OE)
		else $error("fault in reset");
	a_bst_own: assert property (ok && BOOTSTRAP_UV[1] |=> HB_HIZ[1])
		else $error("bst not off");
	a_cbc_flip: assert property (ok && CYCLE_CURRENT_LIMIT && $rose(OVERCURRENT[0]) && !HB_HIZ[0]
		|=> HB_FLIP[0])
		else $error("no flip");
	a_frame_clear: assert property (ok && FRAME_START && !OVERCURRENT |=> !HB_FLIP)
		else $error("flip kept");
	a_ovl_hold: assert property (OVERLOAD_PROTECTION |=> OVERLOAD_PROTECTION && FAULT_N_OE)
		else $error("overload lost");
	a_hot_latch: assert property (THERMAL_SHUTDOWN |=> THERMAL_SHUTDOWN && HB_HIZ == 4'hf)
		else $error("thermal lost");
	a_lat_first: assert property (ok && !CYCLE_CURRENT_LIMIT && OVERCURRENT[3] |-> ##[1:2] HB_HIZ[3])
		else $error("latched oc late");
endmodule
bind apf_protect apf_chk u_chk (.*);

/* tb/apf_ctrl.sv */
/* Controller model: pull-ups, reset driver.
 Assumes req from the bench asks for reset. */
`timescale 1ns/1ps
module apf_ctrl (
	input  logic clk,
	input  logic req,
	input  logic f_o,
	input  logic f_oe,
	input  logic w_o,
	input  logic w_oe,
	output logic fault_pin,
	output logic warn_pin,
	output logic rst_n
);
	assign fault_pin = f_oe ? f_o : 1'b1;
	assign warn_pin  = w_oe ? w_o : 1'b1;
	initial rst_n = 1'b0;
	// Hot release would retrip thermal
	always @(posedge clk) rst_n <= !req && (rst_n || warn_pin);
endmodule

/* tb/tb_top.sv */
/* Bench for apf_protect with controller model.
 Assumes 40 MHz clock; checks at falling edge. */
`timescale 1ns/1ps
module tb_top;
	logic       clk = 0, req = 1, fs = 0, tw = 0, tl = 0, uv = 0, ce = 1;
	logic [1:0] md = 0, thr;
	logic [3:0] st = 0, bu = 0, oc = 0, hiz, flp;
	logic       fo, foe, wo, woe, fp, wp, rn, ccl, ovl, ts;
	logic [7:0] tab [6] = '{8'h03, 8'h19, 8'h3c, 8'h6f, 8'h93, 8'hac};
	int         miscompares = 0, comparisons = 0;
	always #12.5 clk = ~clk;
	apf_protect dut (.CORE_CLK(clk), .RST_N(rn), .CLK_EN(ce), .FRAME_START(fs),
		.OUTPUT_MODE(md), .CURRENT_LIMIT_STRAP(st), .TEMP_WARNING(tw), .THERMAL_LIMIT(tl),
		.UNDERVOLTAGE_PROTECTION(uv), .BOOTSTRAP_UV(bu), .OVERCURRENT(oc), .FAULT_N_O(fo),
		.FAULT_N_OE(foe), .CLIP_TEMP_WARN_N_O(wo), .CLIP_TEMP_WARN_N_OE(woe), .HB_HIZ(hiz),
		.HB_FLIP(flp), .OC_THRESHOLD(thr), .CYCLE_CURRENT_LIMIT(ccl),
		.OVERLOAD_PROTECTION(ovl), .THERMAL_SHUTDOWN(ts));
	apf_ctrl u_ctl (.clk(clk), .req(req), .f_o(fo), .f_oe(foe), .w_o(wo), .w_oe(woe),
		.fault_pin(fp), .warn_pin(wp), .rst_n(rn));
	task e(int n); repeat (n) @(posedge clk); endtask
	task c(logic [3:0] g, x);
		comparisons++;
		if (g !== x) begin
			miscompares++;
			$display("MISMATCH %0t %h %h", $time, g, x);
		end
	endtask
	task rs(logic [3:0] t, logic [1:0] m);
		req <= 1; st <= t; md <= m; oc <= 0; tl <= 0;
		e(10); req <= 0; e(4);
	endtask
	// Overcurrent held past counter top
	task ov(logic [1:0] m, logic [1:0] h, logic [3:0] x);
		rs(4'h0, m); oc[h] <= 1; e(20); oc <= 0; e(3); @(negedge clk);
		c(hiz, x);
		c({3'h0, fp}, 4'h0);
		c({3'h0, ovl}, 4'h1);
	endtask
	task final_report();
		$display("Compares %0d, mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		rs(4'h1, 2'h0); @(negedge clk);
		c({thr, 1'b0, ccl}, 4'h5);
		e(1); ce <= 0; uv <= 1; e(2); ce <= 1; uv <= 0; @(negedge clk);
		c({2'h0, hiz[0], fp}, 4'h1);
		e(1); uv <= 1; tw <= 1; e(1); @(negedge clk);
		c(hiz, 4'hf);
		c({2'h0, fp, wp}, 4'h0);
		e(1); uv <= 0; e(2); @(negedge clk);
		c({hiz[1:0], fp, wp}, 4'h2);
		e(1); tw <= 0; uv <= 1; e(1); @(negedge clk);
		c({2'h0, fp, wp}, 4'h1);
		e(1); uv <= 0; bu <= 4'h2; e(2); @(negedge clk);
		c({hiz[3:1], fp}, 4'h3);
		e(1); bu <= 0; oc <= 4'h1; e(1); oc <= 0; @(negedge clk);
		c(flp, 4'h1);
		e(1); fs <= 1; e(1); fs <= 0; @(negedge clk);
		c({flp[2:0], ovl}, 4'h0);
		rs(4'ha, 2'h0); oc <= 4'h8; e(1); oc <= 0; e(1); @(negedge clk);
		c(hiz, 4'hc);
		c({thr, 1'b0, ccl}, 4'h8);
		rs(4'h5, 2'h0); @(negedge clk);
		c({thr, 1'b0, ccl}, 4'hd);
		e(1); tl <= 1; e(1); tl <= 0; e(3); @(negedge clk);
		c({2'h0, ts, fp}, 4'h2);
		e(1); req <= 1; e(3); @(negedge clk);
		c({3'h0, fp}, 4'h1);
		foreach (tab[i]) ov(tab[i][7:6], tab[i][5:4], tab[i][3:0]);
		final_report();
	end
	initial begin
		e(3000);
		miscompares++;
		final_report();
	end
endmodule
